// >>> list_sweep_handler_signals.sv
`timescale 1ns/10ps
module list_sweep_handler_signals
  import sweep_handler_pkg::*;
#(
  parameter int NUM_POINTS = MAX_POINTS
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Sweep setup
  input wire logic sequential_sweep_in,
  input wire logic ext_trigger_mode_in,
  input wire logic int_trigger_in,
  input wire logic ext_trigger_n_in,
  // Measurement engine
  input wire logic analog_done_in,
  input wire logic cmp_done_in,
  input wire logic cmp_fail_in,
  // Engine control
  output logic meas_start_out,
  output logic [PT_IDX_W-1:0] point_index_out,
  // Handler pins
  output logic [NUM_POINTS-2:0] point_fail_n_out,
  output logic point_fail_10_n_out,
  output logic overall_judgement_n_out,
  output logic analog_done_n_out,
  output logic meas_end_n_out
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  sweep_state_t state_reg, state_next;
  logic [PT_IDX_W-1:0] pt_reg, pt_next;
  logic [NUM_POINTS-1:0] fail_acc_reg, fail_acc_next;
  logic [NUM_POINTS-1:0] fail_out_reg, fail_out_next;
  logic judge_reg, judge_next;
  logic index_reg, index_next;
  logic end_reg, end_next;
  logic start_reg, start_next;
  logic trig_prev_reg;
  logic trig_rise;
  logic go;
  logic last_pt;

  // Handler trigger fires on the pin's low-to-high edge; the detector resets to the
  // pin's idle high level, so no false edge follows reset
  assign trig_rise = ~trig_prev_reg & ext_trigger_n_in;
  assign go = ext_trigger_mode_in ? trig_rise : int_trigger_in;
  assign last_pt = (pt_reg == PT_IDX_W'(NUM_POINTS - 1));

  // Next-state logic of the sweep sequencer
  always_comb begin
    state_next = state_reg;
    pt_next = pt_reg;
    fail_acc_next = fail_acc_reg;
    fail_out_next = fail_out_reg;
    judge_next = judge_reg;
    index_next = PIN_IDLE; // Analog-done is a one-cycle low pulse
    end_next = end_reg;
    start_next = 1'b0;
    case (state_reg)
      ST_IDLE, ST_DONE: begin
        if (go) begin
          state_next = ST_MEAS;
          pt_next = FIRST_POINT;
          fail_acc_next = FAIL_NONE;
          start_next = 1'b1;
          end_next = PIN_IDLE; // End mark holds until here; fail pins and judgement hold until the next list's last comparison
        end
      end
      ST_MEAS: begin
        if (analog_done_in) begin
          state_next = ST_CMP;
          // Step mode flags every point, sequential only the last
          if (!sequential_sweep_in || last_pt) begin
            index_next = PIN_ACTIVE;
          end
        end
      end
      ST_CMP: begin
        if (cmp_done_in) begin
          fail_acc_next[pt_reg] = cmp_fail_in;
          if (last_pt) begin
            state_next = ST_DONE;
            // Publish only after the whole sweep completes
            fail_out_next = fail_acc_reg;
            fail_out_next[pt_reg] = cmp_fail_in;
            judge_next = (|fail_acc_reg) | cmp_fail_in;
            end_next = PIN_ACTIVE;
          end else if (!sequential_sweep_in) begin
            state_next = ST_STEP_WAIT;
            end_next = PIN_ACTIVE; // Step comparison finished
          end else begin
            state_next = ST_MEAS;
            pt_next = pt_reg + PT_ONE;
            start_next = 1'b1;
          end
        end
      end
      ST_STEP_WAIT: begin
        // Step mode waits for a trigger per point
        if (go) begin
          state_next = ST_MEAS;
          pt_next = pt_reg + PT_ONE;
          start_next = 1'b1;
          end_next = PIN_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Register stage
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_IDLE;
      pt_reg <= FIRST_POINT;
      fail_acc_reg <= FAIL_NONE;
      fail_out_reg <= FAIL_NONE;
      judge_reg <= 1'b0;
      index_reg <= PIN_IDLE;
      end_reg <= PIN_IDLE;
      start_reg <= 1'b0;
      trig_prev_reg <= PIN_IDLE;
    end else begin
      state_reg <= state_next;
      pt_reg <= pt_next;
      fail_acc_reg <= fail_acc_next;
      fail_out_reg <= fail_out_next;
      judge_reg <= judge_next;
      index_reg <= index_next;
      end_reg <= end_next;
      start_reg <= start_next;
      trig_prev_reg <= ext_trigger_n_in;
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  logic [NUM_POINTS-1:0] fail_n_reg;

  // Fail flags inverted to active low; loaded on the edge of the end mark,
  // never with analog-done, so a handler that swaps parts early reads nothing new
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fail_n_reg <= {NUM_POINTS{PIN_IDLE}};
      overall_judgement_n_out <= PIN_IDLE;
    end else begin
      fail_n_reg <= ~fail_out_next;
      overall_judgement_n_out <= ~judge_next;
    end
  end

  // Outputs are plain wires from the registers above
  assign point_fail_n_out = fail_n_reg[NUM_POINTS-2:0];
  assign point_fail_10_n_out = fail_n_reg[NUM_POINTS-1];
  assign analog_done_n_out = index_reg;
  assign meas_end_n_out = end_reg;
  assign meas_start_out = start_reg;
  assign point_index_out = pt_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Final comparison of a list, in either sweep mode
  logic last_cmp;
  assign last_cmp = (state_reg == ST_CMP) && cmp_done_in && last_pt;

  sequence s_last_cmp;
    last_cmp;
  endsequence

  // Analog-done is low for exactly one cycle
  sequence s_index_pulse;
    !analog_done_n_out ##1 analog_done_n_out;
  endsequence

  // Publishing of results at the end of a list
  a_end_after_list: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_last_cmp |=> !meas_end_n_out) else $error("end mark missing after last point");
  a_results_stable: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !meas_end_n_out && !$past(meas_end_n_out) |-> $stable(fail_n_reg))
    else $error("results moved while end mark low");
  a_fail_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !$past(last_cmp) |-> $stable(fail_n_reg)) else $error("early result change");
  a_judge_or: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    overall_judgement_n_out == ~(|(~fail_n_reg))) else $error("judgement mismatch");
  a_point_fail: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    last_cmp && cmp_fail_in |=> !point_fail_10_n_out) else $error("point fail lost");

  // Analog-done timing in both sweep modes
  a_last_index_only: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    sequential_sweep_in && state_reg == ST_MEAS && analog_done_in && !last_pt
    |=> analog_done_n_out) else $error("early analog done in sequential mode");
  a_final_index_pulse: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    sequential_sweep_in && state_reg == ST_MEAS && analog_done_in && last_pt
    |=> s_index_pulse) else $error("final analog done missing");
  a_step_index: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !sequential_sweep_in && state_reg == ST_MEAS && analog_done_in
    |=> s_index_pulse) else $error("step analog done pulse wrong");
  a_index_no_result: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !analog_done_n_out |-> $stable(fail_n_reg)) else $error("results moved at analog done");

  // Step end mark and trigger handling
  a_step_end: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !sequential_sweep_in && state_reg == ST_CMP && cmp_done_in |=> !meas_end_n_out)
    else $error("step end mark missing");
  a_trigger_start: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state_reg == ST_IDLE || state_reg == ST_DONE || state_reg == ST_STEP_WAIT)
    && ext_trigger_mode_in && trig_rise |=> meas_start_out)
    else $error("trigger edge ignored");
  a_busy_no_start: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_reg == ST_MEAS |=> !meas_start_out) else $error("start while measuring");
endmodule

// >>> sweep_handler_pkg.sv
package sweep_handler_pkg;
  // ----------------------------------------
  // Sweep geometry
  // ----------------------------------------
  localparam int MAX_POINTS = 10;
  localparam int PT_IDX_W = 4;
  localparam logic [PT_IDX_W-1:0] FIRST_POINT = 4'h0;
  localparam logic [PT_IDX_W-1:0] PT_ONE = 4'h1;

  // ----------------------------------------
  // Reset values of handler pins (active low, so idle is high)
  // ----------------------------------------
  localparam logic PIN_IDLE = 1'b1;
  localparam logic PIN_ACTIVE = 1'b0;
  localparam logic [MAX_POINTS-1:0] FAIL_NONE = 10'h000;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_MEAS = 3'b001,
    ST_CMP = 3'b010,
    ST_STEP_WAIT = 3'b011,
    ST_DONE = 3'b100
  } sweep_state_t;
endpackage

// >>> handler_model.sv
`timescale 1ns/10ps
module handler_model (
  // Clock and bench command
  input wire logic clk_in,
  input wire logic fire_in,
  // Device pins
  input wire logic meas_end_n_in,
  input wire logic judgement_n_in,
  output logic ext_trigger_n_out,
  // What the handler saw
  output logic seen_fail_out,
  output int end_count_out
);
  logic end_prev = 1'b1;
  initial begin
    ext_trigger_n_out = 1'b1;
    seen_fail_out = 1'b0;
    end_count_out = 0;
  end
  // Pin low one cycle; its release is the trigger edge
  always @(posedge clk_in) begin
    ext_trigger_n_out <= !fire_in;
  end
  // Judgement taken only at the end mark, never at analog-done
  always @(posedge clk_in) begin
    end_prev <= meas_end_n_in;
    if (meas_end_n_in === 1'b0 && end_prev === 1'b1) begin
      seen_fail_out <= !judgement_n_in;
      end_count_out <= end_count_out + 1;
    end
  end
endmodule

// >>> list_sweep_handler_signals_test.sv
`timescale 1ns/10ps
module list_sweep_handler_signals_test;
  import sweep_handler_pkg::*;
  logic clk_in = 0, sys_rst_in = 1, sequential = 1, ext_mode = 0, int_trig = 0;
  logic a_done = 0, c_done = 0, c_fail = 0, fire = 0, ext_n, start, judg_n, adone_n;
  logic end_n, pf10_n, seen_fail;
  logic [3:0] idx;
  logic [8:0] pf_n;
  int mismatches = 0, n_compared = 0, n_start = 0, n_index = 0, n_end;
  always #5 clk_in = ~clk_in;
  // Event counters, so a one-cycle pulse is never missed
  always @(posedge clk_in) begin
    if (start === 1'b1) n_start <= n_start + 1;
    // Each analog-done pulse is where the handler may swap the part
    if (adone_n === 1'b0) n_index <= n_index + 1;
  end
  list_sweep_handler_signals u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .sequential_sweep_in(sequential), .ext_trigger_mode_in(ext_mode),
    .int_trigger_in(int_trig),
    .ext_trigger_n_in(ext_n), .analog_done_in(a_done), .cmp_done_in(c_done),
    .cmp_fail_in(c_fail), .meas_start_out(start), .point_index_out(idx),
    .point_fail_n_out(pf_n), .point_fail_10_n_out(pf10_n),
    .overall_judgement_n_out(judg_n), .analog_done_n_out(adone_n), .meas_end_n_out(end_n));
  handler_model u_handler (.clk_in(clk_in), .fire_in(fire), .meas_end_n_in(end_n),
    .judgement_n_in(judg_n), .ext_trigger_n_out(ext_n), .seen_fail_out(seen_fail),
    .end_count_out(n_end));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic close_out;
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One full list; mode 1 sequential, ext selects the handler pin
  task automatic run_sweep(input logic mode, input logic ext, input logic [9:0] fails);
    int s0, i0, e0, w;
    logic [9:0] prev, exp_pins;
    s0 = n_start;
    i0 = n_index;
    e0 = n_end;
    prev = {pf10_n, pf_n};
    exp_pins = ~fails;
    sequential = mode;
    ext_mode = ext;
    for (int k = 0; k < 10; k++) begin
      if (k == 0 || !mode) begin
        if (ext) fire = 1'b1;
        else int_trig = 1'b1;
        @(negedge clk_in);
        fire = 1'b0;
        int_trig = 1'b0;
      end
      for (w = 0; w < 50 && n_start != s0 + k + 1; w++) @(negedge clk_in);
      if (w == 50) begin
        check("start", 1, 0);
        return;
      end
      check("index", k, idx);
      a_done = 1'b1;
      @(negedge clk_in);
      a_done = 1'b0;
      c_done = 1'b1;
      c_fail = fails[k];
      check("end before compare", 1, end_n);
      if (k == 9) check("pins before end", prev, {pf10_n, pf_n});
      @(negedge clk_in);
      c_done = 1'b0;
      c_fail = 1'b0;
      repeat (2) @(negedge clk_in);
      check("analog done count", i0 + (mode ? (k == 9) : k + 1), n_index);
      check("end count", e0 + (mode ? (k == 9) : k + 1), n_end);
    end
    check("fail pins", exp_pins, {pf10_n, pf_n});
    check("judgement", ~|fails, judg_n);
    check("handler saw fail", |fails, seen_fail);
    repeat (6) @(negedge clk_in);
    check("end held", 0, end_n);
    check("pins held", exp_pins, {pf10_n, pf_n});
  endtask
  // All handler pins idle high after a reset
  task automatic idle_after_reset;
    check("idle pins", 10'h3FF, {pf10_n, pf_n});
    check("idle end", 1, end_n);
    check("idle analog done", 1, adone_n);
    check("idle judgement", 1, judg_n);
  endtask
  // Sequential list, internal start, first and last points out of limits
  task automatic sequential_internal_sweep;
    run_sweep(1'b1, 1'b0, 10'h201);
  endtask
  // Sequential list started by the handler pin, all points good
  task automatic sequential_handler_sweep;
    run_sweep(1'b1, 1'b1, 10'h000);
  endtask
  // Step list, handler pin per point, middle points out of limits
  task automatic step_handler_sweep;
    run_sweep(1'b0, 1'b1, 10'h0F0);
  endtask
  // Step list, internal start per point, every point out of limits
  task automatic step_internal_sweep;
    run_sweep(1'b0, 1'b0, 10'h3FF);
  endtask
  // Reset in the middle of a list drops every pin back to idle
  task automatic reset_mid_sweep;
    sequential = 1'b1;
    ext_mode = 1'b0;
    int_trig = 1'b1;
    @(negedge clk_in);
    int_trig = 1'b0;
    a_done = 1'b1;
    @(negedge clk_in);
    a_done = 1'b0;
    sys_rst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    sys_rst_in = 1'b0;
    idle_after_reset();
    check("reset index", 0, idx);
    check("reset start", 0, start);
  endtask
  initial begin
    repeat (12) @(negedge clk_in);
    sys_rst_in = 1'b0;
    idle_after_reset();
    sequential_internal_sweep();
    sequential_handler_sweep();
    step_handler_sweep();
    step_internal_sweep();
    reset_mid_sweep();
    close_out();
  end
endmodule
